/* File: hdl/pin_strap_switch_config.sv */
// Strap-pin configuration loader for the switch control registers
`timescale 1ns/1ps
module pin_strap_switch_config
    import strap_cfg_pkg::*;
#(
    parameter int NUM_EQ = EQ_CHANNELS
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Board strap pins
    input  wire logic              strap_hs_enable,
    input  wire logic [1:0]        strap_source_select,
    input  wire logic              strap_equalization_level,
    input  wire logic [1:0]        strap_preemphasis_level,
    input  wire logic              strap_drive_current,
    // Serial control side
    input  wire logic              serial_access,
    input  wire logic              serial_we,
    input  wire logic [2:0]        serial_reg_sel,
    input  wire logic [REG_W-1:0]  serial_wdata,
    // Register contents
    output logic [REG_W-1:0]       high_speed_switch_modes,
    output logic [REG_W-1:0]       auxiliary_switch_modes,
    output logic [REG_W-1:0]       receiver_termination_settings,
    output logic [REG_W-1:0]       termination_pulse_ab,
    output logic [REG_W-1:0]       termination_pulse_c,
    output logic [REG_W-1:0]       equalizer_level_ab,
    output logic [REG_W-1:0]       equalizer_level_c,
    output logic [REG_W-1:0]       transmitter_drive_settings,
    // Decoded controls
    output logic                   hs_channels_on,
    output logic [1:0]             hs_source,
    output logic                   aux_switch_on,
    output logic [1:0]             aux_common_port,
    output logic [NUM_EQ-1:0]      eq_high,
    output logic [1:0]             preemphasis,
    output logic                   drive_current_bit,
    output logic                   strap_mode
);
    localparam int NUM_REGS = 8;
    localparam int SYNC_W   = 7;

    logic [SYNC_W-1:0] strap_sync_bus;
    logic              s_en;
    logic [1:0]        s_sel;
    logic              s_eq;
    logic [1:0]        s_pe;
    logic              s_ocl;

    // Pins are asynchronous to clk
    strap_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pin_in   ({strap_hs_enable, strap_source_select, strap_equalization_level,
                    strap_preemphasis_level, strap_drive_current}),
        .pin_sync (strap_sync_bus)
    );

    assign {s_en, s_sel, s_eq, s_pe, s_ocl} = strap_sync_bus;

    cfg_src_t         src_ff;
    cfg_src_t         nxt_src;
    logic [REG_W-1:0] regs_ff [NUM_REGS];
    logic [REG_W-1:0] nxt_regs [NUM_REGS];
    logic [REG_W-1:0] strap_regs [NUM_REGS];

    always_comb begin
        nxt_src = src_ff;
        case (src_ff)
            CFG_STRAP:  if (serial_access) nxt_src = CFG_SERIAL;
            CFG_SERIAL: nxt_src = CFG_SERIAL;
            default:    nxt_src = CFG_STRAP;
        endcase
    end

    // Strap image of every register
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            strap_regs[i] = REG_ZERO;
        end
        strap_regs[0][HS_EN_BIT]               = s_en;
        strap_regs[0][SEL_LSB +: SEL_W]        = s_sel;
        strap_regs[1][HS_EN_BIT]               = AUX_EN_FIXED;
        strap_regs[1][SEL_LSB +: SEL_W]        = s_sel;
        strap_regs[2][RX_TO_BIT]               = RX_TO_FIXED;
        strap_regs[3]                          = PULSE_FIXED;
        strap_regs[4]                          = PULSE_FIXED;
        strap_regs[5]                          = {REG_W{s_eq}};
        strap_regs[6][NUM_EQ-EQ_AB_BITS-1:0]   = {(NUM_EQ - EQ_AB_BITS){s_eq}};
        strap_regs[7][TX_PE_LSB +: TX_PE_W]    = s_pe;
        strap_regs[7][DRIVE_CURRENT_BIT_BIT]              = s_ocl;
    end

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (src_ff == CFG_STRAP) begin
                nxt_regs[i] = strap_regs[i];
            end else begin
                nxt_regs[i] = regs_ff[i];
            end
        end
        // Write in the handover cycle lands on the strap image's place
        if (serial_access && serial_we) begin
            nxt_regs[serial_reg_sel] = serial_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_ff <= CFG_STRAP;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= REG_ZERO;
            end
        end else begin
            src_ff <= nxt_src;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    assign high_speed_switch_modes       = regs_ff[0];
    assign auxiliary_switch_modes        = regs_ff[1];
    assign receiver_termination_settings = regs_ff[2];
    assign termination_pulse_ab          = regs_ff[3];
    assign termination_pulse_c           = regs_ff[4];
    assign equalizer_level_ab            = regs_ff[5];
    assign equalizer_level_c             = regs_ff[6];
    assign transmitter_drive_settings    = regs_ff[7];
    assign strap_mode                    = (src_ff == CFG_STRAP);

    assign hs_channels_on    = regs_ff[0][HS_EN_BIT];
    assign hs_source         = regs_ff[0][SEL_LSB +: SEL_W];
    assign aux_switch_on     = regs_ff[1][HS_EN_BIT];
    assign aux_common_port   = regs_ff[1][SEL_LSB +: SEL_W];
    // per input level, 1 is 12 dB
    assign eq_high           = {regs_ff[6][NUM_EQ-EQ_AB_BITS-1:0], regs_ff[5]};
    assign preemphasis       = regs_ff[7][TX_PE_LSB +: TX_PE_W];
    assign drive_current_bit = regs_ff[7][DRIVE_CURRENT_BIT_BIT];

    // Assertions
    // Reset leaves zeros, so the first strap image lands a cycle after release
    sequence s_loaded;
        resetn && strap_mode && !serial_access ##1 resetn && strap_mode;
    endsequence

    sequence s_strap_steady;
        s_loaded ##0 $stable(strap_sync_bus);
    endsequence

    property p_en_follows;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> hs_channels_on == s_en;
    endproperty
    a_en_follows: assert property (p_en_follows) else $error("enable not from strap");

    property p_sel_both;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> hs_source == s_sel && aux_common_port == s_sel;
    endproperty
    a_sel_both: assert property (p_sel_both) else $error("source select mismatch");

    property p_aux_on;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> aux_switch_on;
    endproperty
    a_aux_on: assert property (p_aux_on) else $error("aux not enabled");

    property p_term_fixed;
        @(posedge clk) disable iff (!resetn)
        s_loaded |->
            receiver_termination_settings[RX_TO_BIT] && termination_pulse_ab == PULSE_FIXED
            && termination_pulse_c == PULSE_FIXED;
    endproperty
    a_term_fixed: assert property (p_term_fixed) else $error("termination fields wrong");

    property p_eq_fan;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> eq_high == {NUM_EQ{s_eq}};
    endproperty
    a_eq_fan: assert property (p_eq_fan) else $error("equalizer not uniform");

    property p_tx_map;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> preemphasis == s_pe && drive_current_bit == s_ocl;
    endproperty
    a_tx_map: assert property (p_tx_map) else $error("transmitter fields wrong");

    property p_zero_bits;
        @(posedge clk) disable iff (!resetn)
        $past(strap_mode) && strap_mode |-> high_speed_switch_modes[5:2] == 4'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");

    property p_handover;
        @(posedge clk) disable iff (!resetn)
        serial_access |=> !strap_mode ##1 !strap_mode;
    endproperty
    a_handover: assert property (p_handover) else $error("strap mode after access");

    property p_serial_holds;
        @(posedge clk) disable iff (!resetn)
        !strap_mode && !serial_access |=> $stable(high_speed_switch_modes);
    endproperty
    a_serial_holds: assert property (p_serial_holds) else $error("straps leak");

    property p_aux_port;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> aux_common_port == s_sel;
    endproperty
    a_aux_port: assert property (p_aux_port) else $error("aux port not from strap");

    property p_drive;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> drive_current_bit == s_ocl;
    endproperty
    a_drive: assert property (p_drive) else $error("drive current not from strap");

    property p_preemph;
        @(posedge clk) disable iff (!resetn)
        s_strap_steady |-> preemphasis == s_pe;
    endproperty
    a_preemph: assert property (p_preemph) else $error("pre-emphasis not from strap");

    property p_eq_level;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> eq_high == {NUM_EQ{1'b0}} || eq_high == {NUM_EQ{1'b1}};
    endproperty
    a_eq_level: assert property (p_eq_level) else $error("equalizer level mixed");

    property p_pulse_zero;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> termination_pulse_ab == REG_ZERO && termination_pulse_c == REG_ZERO;
    endproperty
    a_pulse_zero: assert property (p_pulse_zero) else $error("pulse feature on");

    property p_rx_rest;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> receiver_termination_settings[REG_W-1:RX_TO_BIT+1] == '0;
    endproperty
    a_rx_rest: assert property (p_rx_rest) else $error("receiver bits set");

    property p_aux_rest;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> auxiliary_switch_modes[REG_W-1] == 1'b0
            && auxiliary_switch_modes[HS_EN_BIT-1:SEL_LSB+SEL_W] == '0;
    endproperty
    a_aux_rest: assert property (p_aux_rest) else $error("aux modes bits set");

    property p_hs_top;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> high_speed_switch_modes[REG_W-1] == 1'b0;
    endproperty
    a_hs_top: assert property (p_hs_top) else $error("modes top bit set");

    property p_eq_upper;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> equalizer_level_c[REG_W-1:NUM_EQ-EQ_AB_BITS] == '0;
    endproperty
    a_eq_upper: assert property (p_eq_upper) else $error("equalizer upper bits set");

    property p_tx_rest;
        @(posedge clk) disable iff (!resetn)
        s_loaded |-> transmitter_drive_settings[REG_W-1:TX_PE_LSB+TX_PE_W] == '0
            && transmitter_drive_settings[DRIVE_CURRENT_BIT_BIT+1] == 1'b0;
    endproperty
    a_tx_rest: assert property (p_tx_rest) else $error("transmitter bits set");

    property p_strap_ignored;
        @(posedge clk) disable iff (!resetn)
        !strap_mode && !serial_access |=> $stable(transmitter_drive_settings)
            && $stable(equalizer_level_ab) && $stable(equalizer_level_c);
    endproperty
    a_strap_ignored: assert property (p_strap_ignored) else $error("pins reach serial regs");

    property p_write_lands;
        @(posedge clk) disable iff (!resetn)
        serial_access && serial_we && serial_reg_sel == 3'h7
            |=> transmitter_drive_settings == $past(serial_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("serial write lost");

    property p_leave_strap;
        @(posedge clk) disable iff (!resetn)
        !strap_mode |-> !$past(strap_mode) || $past(serial_access);
    endproperty
    a_leave_strap: assert property (p_leave_strap) else $error("strap mode left alone");
endmodule

/* File: include/strap_cfg_pkg.sv */
// Constants and field layout for the strap-pin configuration loader
//
// How it works
// - Drive current bit: 0 selects 10 mA, 1 selects 20 mA, all outputs.
// - Register fields fill straight from strap pin levels, high is one.
// - Straps apply after reset until the first serial register access.
// - Enable strap 0 turns channels off into standby, 1 turns them on.
// - Source select 00/01/10 routes outputs from group A/B/C; 11 illegal.
// - Same source select picks auxiliary group A/B/C; 11 illegal.
// - Auxiliary switch enable held at one while strap configured.
// - Input termination bit fixed at one while strap configured.
// - Both termination pulse registers read all zeros while strap configured.
// - One equalization strap fills all twelve equalizer bits.
// - Equalization strap 0 gives 6 dB, 1 gives 12 dB.
// - Pre-emphasis straps: 00 none, 01 2 dB, 10 4 dB, 11 6 dB.
// - Modes register: enable in bit 6, source select bits 1:0, others zero.
// - Transmitter register: pre-emphasis bits 3:2, drive current bit 0.
package strap_cfg_pkg;
    localparam int          REG_W         = 8;
    localparam int          EQ_CHANNELS   = 12;
    localparam int          EQ_AB_BITS    = 8;
    // Modes register fields
    localparam int          HS_EN_BIT     = 6;
    localparam int          SEL_LSB       = 0;
    localparam int          SEL_W         = 2;
    // Transmitter register fields
    localparam int          TX_PE_LSB     = 2;
    localparam int          TX_PE_W       = 2;
    localparam int          DRIVE_CURRENT_BIT_BIT    = 0;
    // Receiver register field
    localparam int          RX_TO_BIT     = 0;
    // Fixed values in strap mode
    localparam logic        AUX_EN_FIXED  = 1'b1;
    localparam logic        RX_TO_FIXED   = 1'b1;
    localparam logic [7:0]  PULSE_FIXED   = 8'h00;
    localparam logic [7:0]  REG_ZERO      = 8'h00;
    // Source select codes
    localparam logic [1:0]  SEL_A         = 2'h0;
    localparam logic [1:0]  SEL_B         = 2'h1;
    localparam logic [1:0]  SEL_C         = 2'h2;
    localparam logic [1:0]  SEL_ILLEGAL   = 2'h3;
    // Analog figures, for reference by the analog side
    localparam int          DRIVE_LOW_MA  = 10;
    localparam int          DRIVE_HIGH_MA = 20;
    localparam int          EQ_LOW_DB     = 6;
    localparam int          EQ_HIGH_DB    = 12;
    typedef enum logic [1:0] {PE_0DB, PE_2DB, PE_4DB, PE_6DB} preemph_t;
    typedef enum {CFG_STRAP, CFG_SERIAL} cfg_src_t;
endpackage

/* File: hdl/strap_sync.sv */
// Two-flop synchroniser for a bundle of strap pins
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Pins and result
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = pin_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign pin_sync = sync_ff;
endmodule

/* File: verif/strap_board.sv */
// Board strap pins model, levels tied by the bench
`timescale 1ns/1ps
module strap_board (
    // Requested levels {en, sel[1:0], eq, pe[1:0], ocl}
    input  wire logic [6:0] cfg,
    // Strap pins
    output logic            hs_enable,
    output logic [1:0]      source_select,
    output logic            eq_level,
    output logic [1:0]      preemph_level,
    output logic            drive_current
);
    // tie high is one, never 11
    assign source_select = (cfg[5:4] == 2'h3) ? 2'h2 : cfg[5:4];
    assign hs_enable     = cfg[6];
    assign eq_level      = cfg[3];
    assign preemph_level = cfg[2:1];
    assign drive_current = cfg[0];
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the strap-pin configuration loader
`timescale 1ns/1ps
module tb
    import strap_cfg_pkg::*;
;
    logic             clk;
    logic             resetn;
    logic [6:0]       board_cfg;
    logic             serial_access;
    logic             serial_we;
    logic [2:0]       serial_reg_sel;
    logic [REG_W-1:0] serial_wdata;
    logic             p_en, p_eq, p_ocl;
    logic [1:0]       p_sel, p_pe, hs_source, aux_common_port, preemphasis;
    logic [REG_W-1:0] regs [8];
    logic             hs_channels_on, aux_switch_on, drive_current_bit, strap_mode;
    logic [11:0]      eq_high;
    int               mismatches, compares, cycles;

    strap_board i_strap_board (.cfg(board_cfg), .hs_enable(p_en), .source_select(p_sel),
        .eq_level(p_eq), .preemph_level(p_pe), .drive_current(p_ocl));

    pin_strap_switch_config i_pin_strap_switch_config (.clk(clk), .resetn(resetn),
        .strap_hs_enable(p_en), .strap_source_select(p_sel),
        .strap_equalization_level(p_eq), .strap_preemphasis_level(p_pe),
        .strap_drive_current(p_ocl), .serial_access(serial_access), .serial_we(serial_we),
        .serial_reg_sel(serial_reg_sel), .serial_wdata(serial_wdata),
        .high_speed_switch_modes(regs[0]), .auxiliary_switch_modes(regs[1]),
        .receiver_termination_settings(regs[2]), .termination_pulse_ab(regs[3]),
        .termination_pulse_c(regs[4]), .equalizer_level_ab(regs[5]),
        .equalizer_level_c(regs[6]), .transmitter_drive_settings(regs[7]),
        .hs_channels_on(hs_channels_on), .hs_source(hs_source),
        .aux_switch_on(aux_switch_on), .aux_common_port(aux_common_port),
        .eq_high(eq_high), .preemphasis(preemphasis),
        .drive_current_bit(drive_current_bit), .strap_mode(strap_mode));

    function automatic logic [7:0] exp_reg(input int k, input logic [6:0] c);
        case (k)
            0: return {1'b0, c[6], 4'h0, c[5:4]};
            1: return {1'b0, AUX_EN_FIXED, 4'h0, c[5:4]};
            2: return {7'h00, RX_TO_FIXED};
            5: return {8{c[3]}};
            6: return {4'h0, {4{c[3]}}};
            7: return {4'h0, c[2:1], 1'b0, c[0]};
            default: return PULSE_FIXED;
        endcase
    endfunction

    task automatic final_report();
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Full image and decoded controls against a strap set
    task automatic chk_image(input logic [6:0] c);
        for (int k = 0; k < 8; k++) begin
            chk($sformatf("reg%0d", k), 12'(exp_reg(k, c)), 12'(regs[k]));
        end
        chk("hs_on", 12'(c[6]), 12'(hs_channels_on));
        chk("hs_src", 12'(c[5:4]), 12'(hs_source));
        chk("aux_on", 12'h001, 12'(aux_switch_on));
        chk("aux_port", 12'(c[5:4]), 12'(aux_common_port));
        chk("eq_high", {12{c[3]}}, eq_high);
        chk("preemph", 12'(c[2:1]), 12'(preemphasis));
        chk("drive", 12'(c[0]), 12'(drive_current_bit));
    endtask

    task automatic apply(input logic [6:0] c);
        @(posedge clk);
        board_cfg <= c;
        // Two sync flops plus the register flop
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] k, input logic [7:0] d);
        @(posedge clk);
        serial_access  <= 1'b1;
        serial_we      <= 1'b1;
        serial_reg_sel <= k;
        serial_wdata   <= d;
    endtask

    // Every legal select (not 11), enable, equaliser and pre-emphasis code
    task automatic t_sweep();
        for (int i = 0; i < 12; i++) begin
            apply({i[2], 2'(i % 3), i[3] ^ i[0], i[1:0], i[0] ^ i[2]});
            chk_image({i[2], 2'(i % 3), i[3] ^ i[0], i[1:0], i[0] ^ i[2]});
        end
    endtask

    // Back-to-back serial writes end strap control for good
    task automatic t_handover();
        apply(7'h5b);
        wr(3'h7, 8'h0c);
        wr(3'h5, 8'ha5);
        @(posedge clk);
        serial_access <= 1'b0;
        #1;
        chk("strap_mode", 12'h000, 12'(strap_mode));
        chk("reg7", 12'h00c, 12'(regs[7]));
        chk("eq_high", 12'hfa5, eq_high);
        apply(7'h24);
        chk("reg0", 12'(exp_reg(0, 7'h5b)), 12'(regs[0]));
        chk("reg1", 12'(exp_reg(1, 7'h5b)), 12'(regs[1]));
    endtask

    // Reset in mid-run gives the straps back their hold
    task automatic t_rereset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("strap_mode", 12'h001, 12'(strap_mode));
        chk("reg0", 12'h000, 12'(regs[0]));
        @(posedge clk);
        resetn <= 1'b1;
        apply(7'h66);
        chk_image(7'h66);
        // A read alone also ends strap control
        @(posedge clk);
        serial_access <= 1'b1;
        serial_we     <= 1'b0;
        @(posedge clk);
        serial_access <= 1'b0;
        #1;
        chk("strap_mode", 12'h000, 12'(strap_mode));
        apply(7'h5b);
        chk_image(7'h66);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Run ceiling, far above the roughly 80 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        resetn         = 1'b0;
        board_cfg      = 7'h40;
        serial_access  = 1'b0;
        serial_we      = 1'b0;
        serial_reg_sel = 3'h0;
        serial_wdata   = 8'h00;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_sweep();
        t_handover();
        t_rereset();
        final_report();
    end
endmodule
